// ===== pst_top.sv
// Strap latch top: strap capture, control settings and AHB-Lite registers
//
// Behaviour
// - Every strap is sampled once after reset release and becomes initial config.
// - Duplex strap loads control bit 8 the cycle after capture; low means full duplex.
// - Duplex strap high, the pull-up default, selects half duplex.
// - Autoneg strap loads control bit 12; high enables, low disables.
// - Broadcast-off low makes address 0 broadcast; high makes it unique.
// - Address 00000 also answers as own address whenever phy_addr is 00000, whatever the broadcast-off strap.
// - NAND tree strap low enables test mode; high leaves it off.
`timescale 1ns/1ps
`default_nettype none
`include "pst_map.svh"

module pst_top (
   // Clock and reset
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   // AHB-Lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic                     hready,
   input  wire logic [31:0]              hwdata,
   output var  logic [31:0]              hrdata,
   output logic                          hreadyout,
   output logic                          hresp,
   // Strap pins
   input  wire logic                     duplex_strap,
   input  wire logic                     autoneg_enable_strap,
   input  wire logic                     broadcast_off_strap,
   input  wire logic                     nand_tree_strap_n,
   // Management address check
   input  wire logic [4:0]               mgmt_addr,
   input  wire logic [4:0]               phy_addr,
   output var  logic                     mgmt_addr_hit,
   output var  logic                     mgmt_addr_bcast,
   // Configuration outputs
   output logic                          duplex_full,
   output logic                          autoneg_en,
   output var  logic                     bcast_addr0_en,
   output var  logic                     nand_tree_en,
   output logic                          straps_valid
);
   import pst_pkg::*;

   // ==================================================
   // Decode helpers

   // Register select from a byte address; misaligned goes unmapped
   function automatic pst_sel_t pst_decode(input logic [31:0] addr);
      pst_sel_t sel;
      sel = PST_SEL_NONE;
      if (addr[1:0] == `PST_ALIGN_ZERO) begin
         if (addr[`PST_ADDR_HI:0] == `PST_CTRL_OFS) begin
            sel = PST_SEL_CTRL;
         end else if (addr[`PST_ADDR_HI:0] == `PST_STAT_OFS) begin
            sel = PST_SEL_STAT;
         end
      end
      return sel;
   endfunction

   // Address 0 is broadcast unless broadcast-off was strapped high
   function automatic logic pst_is_bcast(input logic [4:0] addr, input logic bc_off);
      return (addr == `PST_BCAST_ADDR) && !bc_off;
   endfunction

   // Read view of one register; the control view is the value after this edge
   function automatic logic [31:0] pst_read_word(input pst_sel_t    sel,
                                                 input logic [31:0] ctrl_word,
                                                 input logic [31:0] stat);
      logic [31:0] word;
      word = `PST_WORD_ZERO;
      unique case (sel)
         PST_SEL_CTRL: begin
            word = ctrl_word;
         end
         PST_SEL_STAT: begin
            word = stat;
         end
         PST_SEL_NONE: begin
            word = `PST_WORD_ZERO;
         end
      endcase
      return word;
   endfunction

   // ==================================================
   // Strap synchroniser and capture
   logic [`PST_STRAP_W-1:0] pins;
   logic [`PST_STRAP_W-1:0] level;

   pst_straps_t             pin_set;

   pst_strap_if cap_if ();

   // Fields named one by one so a pin swap cannot hide in a concatenation
   assign pin_set.nand_tree_n    = nand_tree_strap_n;
   assign pin_set.broadcast_off  = broadcast_off_strap;
   assign pin_set.autoneg_enable = autoneg_enable_strap;
   assign pin_set.duplex         = duplex_strap;
   assign pins                   = pin_set;

   pst_sync u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (pins),
      .level   (level)
   );

   pst_capture u_capture (
      .hclk    (hclk),
      .hresetn (hresetn),
      .level   (level),
      .cap     (cap_if.src)
   );

   assign straps_valid = cap_if.valid;

   // ==================================================
   // Captured strap fields, as the status word shows them
   logic cap_duplex;
   logic cap_aneg;
   logic cap_bcoff;
   logic cap_nand_n;

   assign cap_duplex = cap_if.straps.duplex;
   assign cap_aneg   = cap_if.straps.autoneg_enable;
   assign cap_bcoff  = cap_if.straps.broadcast_off;
   assign cap_nand_n = cap_if.straps.nand_tree_n;

   // ==================================================
   // AHB-Lite address phase
   logic        acc_ok;
   pst_sel_t    dp_sel;
   logic        dp_write;
   logic        dp_valid;
   logic        dp_hwrite;
   logic        dp_word;
   logic        rd_take;
   logic        addr_zero_bc;
   logic        addr_own;
   logic [31:0] sw_ctrl;
   pst_sel_t    ap_sel;
   logic        wr_ctrl;
   logic [31:0] ctrl;
   logic [31:0] stat_word;
   logic [31:0] next_ctrl;
   logic [31:0] next_hrdata;

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign acc_ok = hsel && hready && htrans[`PST_HTRANS_ACT];
   assign ap_sel = acc_ok ? pst_decode(haddr) : PST_SEL_NONE;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_sel <= PST_SEL_NONE;
      end else if (hready) begin
         dp_sel <= ap_sel;
      end
   end

   // Address-phase qualifiers carried into the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid <= 1'b0;
      end else if (hready) begin
         dp_valid <= acc_ok;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_hwrite <= 1'b0;
      end else if (hready) begin
         dp_hwrite <= hwrite;
      end
   end

   // Only whole-word writes land; narrower writes are dropped quietly
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_word <= 1'b0;
      end else if (hready) begin
         dp_word <= (hsize == `PST_HSIZE_WORD);
      end
   end

   assign dp_write = dp_valid && dp_hwrite && dp_word;
   assign wr_ctrl  = dp_write && (dp_sel == PST_SEL_CTRL);

   // ==================================================
   // Control word
   // Software part first, so the capture below overrides it in the same cycle
   always_comb begin
      sw_ctrl = ctrl;
      if (wr_ctrl) begin
         sw_ctrl = hwdata & `PST_CTRL_MASK;
      end
   end

   always_comb begin
      next_ctrl = sw_ctrl;
      if (cap_if.load) begin
         // Duplex strap into bit 8, low is full
         next_ctrl[`PST_CTRL_DUPLEX] = !cap_if.straps.duplex;
         next_ctrl[`PST_CTRL_ANEG] = cap_if.straps.autoneg_enable;
      end
   end

   // Software owns the bits after capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `PST_CTRL_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   assign duplex_full = ctrl[`PST_CTRL_DUPLEX];
   assign autoneg_en  = ctrl[`PST_CTRL_ANEG];

   // ==================================================
   // Status word: raw captured levels and capture done
   always_comb begin
      stat_word                  = `PST_WORD_ZERO;
      stat_word[`PST_STAT_DUPLEX] = cap_duplex;
      stat_word[`PST_STAT_ANEG]   = cap_aneg;
      stat_word[`PST_STAT_BCOFF]  = cap_bcoff;
      stat_word[`PST_STAT_NAND_N] = cap_nand_n;
      stat_word[`PST_STAT_VALID]  = cap_if.valid;
   end

   // ==================================================
   // Read data, registered at the address phase
   // A read right behind a write to the same word sees the new value
   always_comb begin
      next_hrdata = pst_read_word(ap_sel, next_ctrl, stat_word);
   end

   // Held between reads so a slow master may sample late without losing data
   assign rd_take = acc_ok && !hwrite;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `PST_WORD_ZERO;
      end else if (rd_take) begin
         hrdata <= next_hrdata;
      end
   end

   // ==================================================
   // Mode outputs from captured straps
   // Broadcast address 0 unless strapped off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bcast_addr0_en <= 1'b1;
      end else begin
         bcast_addr0_en <= !cap_if.straps.broadcast_off;
      end
   end

   // NAND tree on when strap low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nand_tree_en <= 1'b0;
      end else begin
         nand_tree_en <= cap_if.valid && !cap_if.straps.nand_tree_n;
      end
   end

   // ==================================================
   // Management address terms; the broadcast term feeds both match flags, the own term only the hit flag
   assign addr_zero_bc = pst_is_bcast(mgmt_addr, cap_if.straps.broadcast_off);
   assign addr_own     = (mgmt_addr == phy_addr);

   // ==================================================
   // Management address match, one cycle behind mgmt_addr
   // Address 0 as own whenever phy_addr is 0, broadcast off or not
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mgmt_addr_hit <= 1'b0;
      end else begin
         mgmt_addr_hit <= addr_zero_bc || addr_own;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mgmt_addr_bcast <= 1'b0;
      end else begin
         mgmt_addr_bcast <= addr_zero_bc;
      end
   end

endmodule

`default_nettype wire

// ===== pst_map.svh
// Constants of the strap latch: offsets, field positions, reset values, counts
`ifndef PST_MAP_SVH
`define PST_MAP_SVH

// ==================================================
// Register map
`define PST_ADDR_HI        11
`define PST_CTRL_OFS       12'h000
`define PST_STAT_OFS       12'h004
`define PST_ALIGN_ZERO     2'h0

// ==================================================
// Control word fields
`define PST_CTRL_DUPLEX    8
`define PST_CTRL_ANEG      12
`define PST_CTRL_MASK      32'h0000_1100
`define PST_CTRL_RST       32'h0000_1000

// ==================================================
// Status word fields
`define PST_STAT_DUPLEX    0
`define PST_STAT_ANEG      1
`define PST_STAT_BCOFF     2
`define PST_STAT_NAND_N    3
`define PST_STAT_VALID     4

// ==================================================
// Strap defaults: nand_n, broadcast_off, autoneg, duplex
`define PST_STRAP_RST      4'hb
`define PST_STRAP_W        4

// ==================================================
// Capture timing and bus codes
`define PST_SETTLE_CYC     3'h4
`define PST_CNT_ONE        3'h1
`define PST_BCAST_ADDR     5'h00
`define PST_HSIZE_WORD     3'h2
`define PST_HTRANS_ACT     1
`define PST_WORD_ZERO      32'h0000_0000

`endif

// ===== pst_pkg.sv
// Types shared by the strap latch modules
package pst_pkg;

   // ==================================================
   // Strap bundle, laid out as the strap reset value
   typedef struct packed {
      logic nand_tree_n;
      logic broadcast_off;
      logic autoneg_enable;
      logic duplex;
   } pst_straps_t;

   // ==================================================
   // Capture sequence and register select
   typedef enum logic {PST_CAP_SETTLE, PST_CAP_DONE} pst_cap_state_t;

   typedef enum logic [1:0] {PST_SEL_NONE, PST_SEL_CTRL, PST_SEL_STAT} pst_sel_t;

endpackage

// ===== pst_strap_if.sv
// Captured strap levels handed from the capture stage to the top
`timescale 1ns/1ps
`default_nettype none

interface pst_strap_if;
   import pst_pkg::*;

   pst_straps_t straps;
   logic        load;
   logic        valid;

   modport src (output straps, output load, output valid);
   modport dst (input straps, input load, input valid);
endinterface

`default_nettype wire

// ===== pst_sync.sv
// Three-stage strap synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "pst_map.svh"

module pst_sync (
   // Clock and reset
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   // Raw pins and filtered levels
   input  wire logic [`PST_STRAP_W-1:0]  pin,
   output var  logic [`PST_STRAP_W-1:0]  level
);
   import pst_pkg::*;

   logic [`PST_STRAP_W-1:0] s1;
   logic [`PST_STRAP_W-1:0] s2;
   logic [`PST_STRAP_W-1:0] s3;

   // ==================================================
   // One chain per strap; s1 feeds only s2
   genvar i;
   generate
      for (i = 0; i < `PST_STRAP_W; i = i + 1) begin : g_bit
         localparam logic [`PST_STRAP_W-1:0] RST_VEC = `PST_STRAP_RST;
         localparam logic                    RST_BIT = RST_VEC[i];
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1[i]    <= RST_BIT;
               s2[i]    <= RST_BIT;
               s3[i]    <= RST_BIT;
               level[i] <= RST_BIT;
            end else begin
               s1[i] <= pin[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               // A change counts once two stages agree
               if (s2[i] == s3[i]) begin
                  level[i] <= s3[i];
               end
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ===== pst_capture.sv
// One-shot strap capture after reset release
`timescale 1ns/1ps
`default_nettype none
`include "pst_map.svh"

module pst_capture (
   // Clock and reset
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   // Filtered strap levels
   input  wire logic [`PST_STRAP_W-1:0]  level,
   // Captured values
   pst_strap_if.src                      cap
);
   import pst_pkg::*;

   pst_cap_state_t state;
   logic [2:0]     cnt;

   // ==================================================
   // Settle counter: waits for the filter to hold the pin level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 3'h0;
      end else if (state == PST_CAP_SETTLE && cnt != `PST_SETTLE_CYC) begin
         cnt <= cnt + `PST_CNT_ONE;
      end
   end

   // ==================================================
   // State and latch
   // Sample once after release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= PST_CAP_SETTLE;
      end else if (state == PST_CAP_SETTLE && cnt == `PST_SETTLE_CYC) begin
         state <= PST_CAP_DONE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap.straps <= pst_straps_t'(`PST_STRAP_RST);
      end else if (state == PST_CAP_SETTLE && cnt == `PST_SETTLE_CYC) begin
         cap.straps <= pst_straps_t'(level);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap.load <= 1'b0;
      end else begin
         cap.load <= (state == PST_CAP_SETTLE && cnt == `PST_SETTLE_CYC);
      end
   end

   assign cap.valid = (state == PST_CAP_DONE);

endmodule

`default_nettype wire

// ===== pst_assertions.sv
// Checker of strap capture timing, loaded settings, hold and address match
`timescale 1ns/1ps
`default_nettype none

module pst_assertions (
   // Clock and reset
   input wire logic       hclk,
   input wire logic       hresetn,
   // Strap pins and address check
   input wire logic       duplex_strap,
   input wire logic       autoneg_enable_strap,
   input wire logic       broadcast_off_strap,
   input wire logic       nand_tree_strap_n,
   input wire logic [4:0] mgmt_addr,
   input wire logic [4:0] phy_addr,
   input wire logic       mgmt_addr_hit,
   input wire logic       mgmt_addr_bcast,
   // Configuration outputs
   input wire logic       duplex_full,
   input wire logic       autoneg_en,
   input wire logic       bcast_addr0_en,
   input wire logic       nand_tree_en,
   input wire logic       straps_valid
);
   logic [2:0] cyc;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ==================================================
   // Edges since release, saturating so late checks stay armed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc <= 3'h0;
      end else if (cyc != 3'h7) begin
         cyc <= cyc + 3'h1;
      end
   end

   sequence cap_s;
      cyc == 3'h5;
   endsequence

   sequence settled_s;
      cyc == 3'h7;
   endsequence

   // ==================================================
   // Capture and load
   valid_time_a: assert property (straps_valid == (cyc >= 3'h5))
      else $error("capture flag at wrong time");
   duplex_load_a: assert property (cap_s |=> duplex_full == !$past(duplex_strap, 2))
      else $error("duplex not loaded from strap");
   aneg_load_a: assert property (cap_s |=> autoneg_en == $past(autoneg_enable_strap, 2))
      else $error("autoneg not loaded from strap");
   bcast_load_a: assert property (
      cap_s |=> bcast_addr0_en == !$past(broadcast_off_strap, 2))
      else $error("broadcast enable not loaded");
   nand_load_a: assert property (cap_s |=> nand_tree_en == !$past(nand_tree_strap_n, 2))
      else $error("nand tree mode not loaded");

   // ==================================================
   // Hold and address match
   strap_hold_a: assert property (settled_s |->
      straps_valid && $stable(bcast_addr0_en) && $stable(nand_tree_en))
      else $error("captured setting moved");
   addr_hit_a: assert property (settled_s |-> mgmt_addr_hit ==
      (($past(mgmt_addr) == 5'h00 && $past(bcast_addr0_en)) || $past(mgmt_addr) == $past(phy_addr)))
      else $error("address hit wrong");
   addr_bcast_a: assert property (settled_s |->
      mgmt_addr_bcast == ($past(mgmt_addr) == 5'h00 && $past(bcast_addr0_en)))
      else $error("broadcast flag wrong");
endmodule

bind pst_top pst_assertions u_chk (.hclk, .hresetn, .duplex_strap, .autoneg_enable_strap,
   .broadcast_off_strap, .nand_tree_strap_n, .mgmt_addr, .phy_addr, .mgmt_addr_hit,
   .mgmt_addr_bcast, .duplex_full, .autoneg_en, .bcast_addr0_en, .nand_tree_en, .straps_valid);

`default_nettype wire

// ===== pst_board.sv
// Board strap model: pull levels through capture, then pins toggle as outputs
`timescale 1ns/1ps
`default_nettype none

module pst_board (
   // Clock, reset and fitted straps
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire pst_pkg::pst_straps_t cfg,
   // Pin levels seen by the device
   output var  pst_pkg::pst_straps_t pins
);
   import pst_pkg::*;

   logic [3:0]  cnt;
   pst_straps_t tog;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 4'h0;
         tog <= pst_straps_t'(4'h0);
      end else begin
         if (cnt != 4'h8) begin
            cnt <= cnt + 4'h1;
         end
         tog <= (cnt == 4'h8) ? ~tog : cfg;
      end
   end

   // Later pin activity; the pins turn into busy outputs after reset
   assign pins = (hresetn && cnt == 4'h8) ? tog : cfg;
endmodule

`default_nettype wire

// ===== phy_strap_latch_tb.sv
// Self-checking bench of the strap latch
`timescale 1ns/1ps
`default_nettype none
`include "pst_map.svh"

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
   $display("BAD %0t got %h want %h", $time, a, e); end end

module phy_strap_latch_tb;
   import pst_pkg::*;

   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dp;
   logic        hit, bcast, duplex_full, autoneg_en, bcast_en, nand_en, valid;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [4:0]  mgmt_addr, phy_addr;
   logic [31:0] haddr, hwdata, hrdata;
   logic [31:0] exp_q[$];
   logic [31:0] exp_d;
   pst_straps_t cfg, pins;
   int          err_count, num_checks;

   pst_board board (.hclk(hclk), .hresetn(hresetn), .cfg(cfg), .pins(pins));

   pst_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .duplex_strap(pins.duplex), .autoneg_enable_strap(pins.autoneg_enable),
      .broadcast_off_strap(pins.broadcast_off), .nand_tree_strap_n(pins.nand_tree_n),
      .mgmt_addr(mgmt_addr), .phy_addr(phy_addr), .mgmt_addr_hit(hit),
      .mgmt_addr_bcast(bcast), .duplex_full(duplex_full), .autoneg_en(autoneg_en),
      .bcast_addr0_en(bcast_en), .nand_tree_en(nand_en), .straps_valid(valid));

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Bounded wait for an edge that samples hreadyout high
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            err_count++;
            stop_test;
         end
         @(posedge hclk);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] e);
      if (!w) begin
         exp_q.push_back(e);
      end
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= `PST_HSIZE_WORD;
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
   endtask

   // Read data is taken at the edge that closes the data phase
   always @(posedge hclk) begin
      if (rd_dp === 1'b1 && exp_q.size() > 0) begin
         exp_d = exp_q.pop_front();
         // Response code rides along with the data so hresp is watched too
         `CHK({hresp, hrdata}, {1'b0, exp_d})
      end
      rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
   end

   initial begin
      pst_straps_t c;
      logic [31:0] v;
      int          n;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = `PST_HSIZE_WORD;
      hwdata = 32'h0000_0000;
      mgmt_addr = 5'h00;
      phy_addr = 5'h01;
      cfg = pst_straps_t'(`PST_STRAP_RST);
      void'($urandom(24));
      // Every strap combination, each behind a fresh reset
      for (int i = 0; i < 16; i++) begin
         c = pst_straps_t'(i[3:0]);
         cfg <= c;
         hresetn <= 1'b0;
         repeat (16) @(posedge hclk);
         hresetn <= 1'b1;
         n = 0;
         while (valid !== 1'b1) begin
            n++;
            if (n > 20) begin
               err_count++;
               stop_test;
            end
            @(posedge hclk);
         end
         repeat (2) @(posedge hclk);
         #1;
         `CHK(duplex_full, ~c.duplex)
         `CHK(autoneg_en, c.autoneg_enable)
         `CHK(bcast_en, ~c.broadcast_off)
         `CHK(nand_en, ~c.nand_tree_n)
         // Own address zero only in the low half, so address 0 meets both roles
         v = $urandom();
         phy_addr <= v[4:0] & {5{i[3]}};
         mgmt_addr <= i[0] ? v[4:0] : 5'h00;
         repeat (2) @(posedge hclk);
         #1;
         `CHK(hit, (mgmt_addr == 5'h00 && !c.broadcast_off) || mgmt_addr == phy_addr)
         `CHK(bcast, mgmt_addr == 5'h00 && !c.broadcast_off)
         // Control word as loaded from the straps
         bus(1'b0, {20'h0, `PST_CTRL_OFS}, v,
             {19'h0, c.autoneg_enable, 3'h0, ~c.duplex, 8'h0});
         // Captured levels and the done flag
         bus(1'b0, {20'h0, `PST_STAT_OFS}, v, {27'h0, 1'b1, c});
         bus(1'b1, {20'h0, `PST_CTRL_OFS}, v, v);
         // Software owns the control bits, the status stays frozen
         bus(1'b0, {20'h0, `PST_CTRL_OFS}, v, v & `PST_CTRL_MASK);
         bus(1'b1, {20'h0, `PST_STAT_OFS}, ~v, v);
         bus(1'b0, {20'h0, `PST_STAT_OFS}, v, {27'h0, 1'b1, c});
         // Unmapped and misaligned reads return zero
         bus(1'b0, 32'h0000_0008, v, 32'h0000_0000);
         bus(1'b0, 32'h0000_0001, v, 32'h0000_0000);
      end
      repeat (2) @(posedge hclk);
      // Every queued read must have been answered
      `CHK(exp_q.size(), 0)
      stop_test;
   end
endmodule

`default_nettype wire
